//--- logic/bioh_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the byte-wide handshake port.
// ----------------------------------------------------------------------------
package bioh_pkg;

   // Width of the parallel data register.
   localparam int BIOH_DATA_W = 8;

   // Depth of the capture FIFO in words.
   localparam int BIOH_FIFO_DEPTH = 4;

   // Value loaded into the data register by clear and by reset.
   localparam logic [BIOH_DATA_W-1:0] BIOH_REG_CLEAR = 8'h00;

   // Mode strap level that selects input mode.
   localparam logic BIOH_MODE_INPUT = 1'h0;

   // Request flip-flop value after clear and reset.
   localparam logic BIOH_REQ_CLEAR = 1'h0;

   // Number of flip-flop stages in each pin synchroniser.
   localparam int BIOH_SYNC_STAGES = 2;

endpackage

//--- logic/bioh_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Small synchronous FIFO with valid and ready on both sides.
// ----------------------------------------------------------------------------
module bioh_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] wr_ptr_next;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_next;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic push;
   logic pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready = (count_reg != CNT_FULL);
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer and count update; pointers wrap at the last slot.
   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next = count_reg;
      if (push) begin
         wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : PTR_W'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
         rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : PTR_W'(rd_ptr_reg + 1'b1);
      end
      if (push && !pop) begin
         count_next = CNT_W'(count_reg + 1'b1);
      end else if (pop && !push) begin
         count_next = CNT_W'(count_reg - 1'b1);
      end
   end

   // Control state registers.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
   end

   // Storage is written only on an accepted push and needs no reset.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

endmodule

`default_nettype wire

//--- logic/bioh_port.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - With the mode strap low the port works as an input port, taking peripheral bytes for the processor.
// - In input mode the register follows the data inputs while the strobe is high and holds from its fall.
// - In input mode the service request goes low at the strobe's falling edge to flag a ready byte.
// - In input mode the port is selected only with both selects high, and then drives the register out.
// - In input mode, when either select drops, the outputs float and the service request returns high.
// - With the mode strap high the port is an output port whose drivers stay enabled all the time.
// - In output mode the port is selected with the first select low and the second select high.
// - In output mode, while selected with the strobe high, bus data passes through and latches at the fall.
// - In output mode the register is always visible on the outputs, also after deselection.
// - In output mode the service request rises on deselection and falls at the next strobe falling edge.
// - In input mode any momentary selection drives the service request low and sets the request latch.
// - Clear low with the strobe low resets the register to zero; clear low resets the request flip-flop, giving the idle request level.

// ----------------------------------------------------------------------------
// Byte-wide latched port with service-request handshake.
// ----------------------------------------------------------------------------
module bioh_port
   import bioh_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic mode_strap,
   input wire logic strobe_clock,
   input wire logic select_one,
   input wire logic select_two,
   input wire logic clear_n,
   input wire logic [BIOH_DATA_W-1:0] data_inputs,
   output logic [BIOH_DATA_W-1:0] data_outputs,
   output logic data_outputs_oe,
   output logic service_request,
   output logic capture_valid,
   input wire logic capture_ready,
   output logic [BIOH_DATA_W-1:0] capture_data,
   output logic capture_space
);

   // ------------------------------------------------------------------------
   // Pin synchronisers.
   // ------------------------------------------------------------------------

   localparam int PIN_W = BIOH_DATA_W + 5;

   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] meta_reg;
   logic [PIN_W-1:0] meta_next;
   logic [PIN_W-1:0] sync_reg;
   logic [PIN_W-1:0] sync_next;

   // Gather every asynchronous pin into one vector.
   assign pins_raw = {mode_strap, strobe_clock, select_one, select_two, clear_n, data_inputs};

   // Two stages; only the second stage is read by the logic.
   always_comb begin
      meta_next = pins_raw;
      sync_next = meta_reg;
   end

   // Synchroniser registers.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   logic mode_s;
   logic clk_s;
   logic sel1_s;
   logic sel2_s;
   logic clr_n_s;
   logic [BIOH_DATA_W-1:0] din_s;

   // Split the synchronised vector back into named levels.
   assign {mode_s, clk_s, sel1_s, sel2_s, clr_n_s, din_s} = sync_reg;

   // ------------------------------------------------------------------------
   // Selection decode and edge detection.
   // ------------------------------------------------------------------------

   // Select decode depends on the strapped mode.
   function automatic logic port_selected(input logic mode, input logic s1, input logic s2);
      if (mode == BIOH_MODE_INPUT) begin
         port_selected = s1 && s2;
      end else begin
         port_selected = !s1 && s2;
      end
   endfunction

   logic input_mode;
   logic selected;
   logic clk_d_reg;
   logic clk_d_next;
   logic sel_d_reg;
   logic sel_d_next;
   logic clk_fall;
   logic sel_rise;
   logic sel_fall;

   assign input_mode = (mode_s == BIOH_MODE_INPUT);
   assign selected = port_selected(mode_s, sel1_s, sel2_s);
   assign clk_fall = clk_d_reg && !clk_s;
   assign sel_rise = selected && !sel_d_reg;
   assign sel_fall = sel_d_reg && !selected;

   // Delayed copies for edge detection.
   always_comb begin
      clk_d_next = clk_s;
      sel_d_next = selected;
   end

   // Edge detector registers.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         clk_d_reg <= 1'h0;
         sel_d_reg <= 1'h0;
      end else begin
         clk_d_reg <= clk_d_next;
         sel_d_reg <= sel_d_next;
      end
   end

   // ------------------------------------------------------------------------
   // Data register and output drivers.
   // ------------------------------------------------------------------------

   logic [BIOH_DATA_W-1:0] latch_reg;
   logic [BIOH_DATA_W-1:0] latch_next;
   logic [BIOH_DATA_W-1:0] dout_reg;
   logic [BIOH_DATA_W-1:0] dout_next;
   logic oe_reg;
   logic oe_next;
   logic load;

   // The register is transparent while its strobe condition holds.
   assign load = input_mode ? clk_s : (clk_s && selected);

   // Register follows the data while loading and holds once the strobe falls.
   always_comb begin
      latch_next = latch_reg;
      if (!clr_n_s && !clk_s) begin
         latch_next = BIOH_REG_CLEAR;
      end else if (load) begin
         latch_next = din_s;
      end
      dout_next = latch_next;
      if (input_mode) begin
         oe_next = selected;
      end else begin
         oe_next = 1'h1;
      end
   end

   // Data register and driver registers.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         latch_reg <= BIOH_REG_CLEAR;
         dout_reg <= BIOH_REG_CLEAR;
         oe_reg <= 1'h0;
      end else begin
         latch_reg <= latch_next;
         dout_reg <= dout_next;
         oe_reg <= oe_next;
      end
   end

   assign data_outputs = dout_reg;
   assign data_outputs_oe = oe_reg;

   // ------------------------------------------------------------------------
   // Service request flip-flop.
   // ------------------------------------------------------------------------

   logic req_reg;
   logic req_next;
   logic req_set;
   logic req_clr;
   logic sr_reg;
   logic sr_next;

   // Input mode sets on strobe fall or any selection, clears on deselect.
   // Output mode sets on deselect and clears on the next strobe fall.
   // A set in the same cycle as a clear wins.
   always_comb begin
      if (input_mode) begin
         req_set = clk_fall || sel_rise;
         req_clr = sel_fall;
      end else begin
         req_set = sel_fall;
         req_clr = clk_fall;
      end
      req_next = req_reg;
      if (!clr_n_s) begin
         req_next = BIOH_REQ_CLEAR;
      end else if (req_set) begin
         req_next = 1'h1;
      end else if (req_clr) begin
         req_next = 1'h0;
      end
      sr_next = input_mode ? !req_next : req_next;
   end

   // Request flip-flop and its output register.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         req_reg <= BIOH_REQ_CLEAR;
         sr_reg <= 1'h1;
      end else begin
         req_reg <= req_next;
         sr_reg <= sr_next;
      end
   end

   assign service_request = sr_reg;

   // ------------------------------------------------------------------------
   // Capture FIFO of latched bytes.
   // ------------------------------------------------------------------------

   logic push_valid;

   // Each byte latched by a strobe fall is offered; a full FIFO drops it.
   assign push_valid = clk_fall && clr_n_s && (input_mode || sel_d_reg);

   bioh_fifo #(
      .WIDTH(BIOH_DATA_W),
      .DEPTH(BIOH_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .in_valid(push_valid),
      .in_ready(capture_space),
      .in_data(latch_reg),
      .out_valid(capture_valid),
      .out_ready(capture_ready),
      .out_data(capture_data)
   );

endmodule

`default_nettype wire

//--- test/bioh_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Checker on the port pins.
// ------
module bioh_port_chk
   import bioh_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic mode_strap,
   input wire logic strobe_clock,
   input wire logic select_one,
   input wire logic select_two,
   input wire logic clear_n,
   input wire logic [BIOH_DATA_W-1:0] data_inputs,
   input wire logic [BIOH_DATA_W-1:0] data_outputs,
   input wire logic data_outputs_oe,
   input wire logic service_request,
   input wire logic capture_valid,
   input wire logic capture_ready,
   input wire logic [BIOH_DATA_W-1:0] capture_data,
   input wire logic capture_space
);
   logic [2:0] up_reg;
   logic [2:0] up_next;
   logic m_reg;
   logic ok;
   logic sb;
   logic sel;
   // Settle count restarts on reset and on a mode change, since pins lag by three edges.
   always_comb begin
      up_next = up_reg + {2'h0, up_reg != 3'h7};
      if (!rstn || mode_strap != m_reg) begin
         up_next = 3'h0;
      end
   end
   // Registers of the settle counter.
   always_ff @(posedge sys_clk) begin
      up_reg <= up_next;
      m_reg <= mode_strap;
   end
   assign ok = up_reg == 3'h7;
   assign sb = select_one & select_two;
   assign sel = m_reg ? (!select_one & select_two) : sb;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_oe_input:
      assert property (ok && !m_reg |-> data_outputs_oe == $past(sb, 3))
      else $error("oe wrong in input mode");
   a_oe_always:
      assert property (ok && m_reg |-> data_outputs_oe)
      else $error("oe low in output mode");
   a_sr_strobe:
      assert property (ok && $past(strobe_clock, 4) && !$past(strobe_clock, 3)
         && $past(clear_n, 3) |-> !service_request) else $error("request not low");
   a_sr_deselect:
      assert property (ok && $past(sel, 4) && !$past(sel, 3) && $past(clear_n, 3)
         |-> service_request) else $error("request not high after deselect");
   a_sr_select:
      assert property (ok && !m_reg && $past(sb, 3) && !$past(sb, 4) |-> !service_request)
      else $error("selection left request high");
   a_data_pass:
      assert property (ok && $past(strobe_clock, 3) && (!m_reg || $past(sel, 3))
         |-> data_outputs == $past(data_inputs, 3)) else $error("data not passed");
   a_data_hold:
      assert property (ok && !$past(strobe_clock, 3) && !$past(strobe_clock, 4)
         && $past(clear_n, 3) && $past(clear_n, 4) |-> $stable(data_outputs))
      else $error("latched data moved");
   a_clear_reg:
      assert property (ok && !$past(strobe_clock, 3) && !$past(clear_n, 3)
         |-> data_outputs == BIOH_REG_CLEAR) else $error("clear left data");
   a_clear_req:
      assert property (ok && !$past(clear_n, 3) |-> service_request == !m_reg)
      else $error("clear gave wrong request level");
endmodule
bind bioh_port bioh_port_chk bioh_port_chk_inst (.sys_clk, .rstn, .mode_strap,
   .strobe_clock, .select_one, .select_two, .clear_n, .data_inputs, .data_outputs,
   .data_outputs_oe, .service_request, .capture_valid, .capture_ready, .capture_data,
   .capture_space);
`default_nettype wire

//--- test/bioh_peri.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Model of the processor and peripheral pins.
// ------
module bioh_peri
   import bioh_pkg::*;
(
   input wire logic sys_clk,
   output logic strobe_clock,
   output logic select_one,
   output logic select_two,
   output logic [BIOH_DATA_W-1:0] data_inputs
);
   // Lines start idle.
   initial begin
      strobe_clock = 1'h0;
      select_one = 1'h0;
      select_two = 1'h0;
      data_inputs = 8'h5a;
   end
   // Select levels as an instruction cycle sets them, then wait.
   task automatic sel(input logic s1, input logic s2, input int n);
      select_one <= s1;
      select_two <= s2;
      repeat (n) @(posedge sys_clk);
   endtask
   // Strobe one byte; data holds past the fall, then the bus is driven to the inverted byte.
   task automatic strobe(input logic [BIOH_DATA_W-1:0] d, input int slow);
      data_inputs <= d;
      strobe_clock <= 1'h1;
      repeat (3 + slow) @(posedge sys_clk);
      strobe_clock <= 1'h0;
      repeat (3) @(posedge sys_clk);
      data_inputs <= ~d;
      repeat (3) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

//--- test/tb_byte_io_port_handshake.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Bench for the handshake port.
// ------
module tb_byte_io_port_handshake
   import bioh_pkg::*;
;
   logic sys_clk = 1'h0;
   logic rstn = 1'h0;
   logic mode_strap = 1'h0;
   logic clear_n = 1'h1;
   logic capture_ready = 1'h0;
   logic strobe_clock, select_one, select_two, data_outputs_oe, service_request;
   logic capture_valid, capture_space;
   logic [BIOH_DATA_W-1:0] data_inputs, data_outputs, capture_data, d;
   logic [BIOH_DATA_W-1:0] q[$];
   int fails = 0;
   int checks_done = 0;
   // Clock at 20 MHz.
   always #25 sys_clk = ~sys_clk;
   bioh_port bioh_port_inst (.sys_clk, .rstn, .mode_strap, .strobe_clock, .select_one,
      .select_two, .clear_n, .data_inputs, .data_outputs, .data_outputs_oe, .service_request,
      .capture_valid, .capture_ready, .capture_data, .capture_space);
   bioh_peri bioh_peri_inst (.sys_clk, .strobe_clock, .select_one, .select_two, .data_inputs);
   // Expected selection for a mode and select levels.
   function automatic logic sel_exp(input logic m, input logic s1, input logic s2);
      return m ? (!s1 && s2) : (s1 && s2);
   endfunction
   // Verdict and end of run.
   task automatic close_out;
      if (fails == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Compare one bit.
   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   // Compare one byte.
   task automatic chk8(input logic [BIOH_DATA_W-1:0] got, input logic [BIOH_DATA_W-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   // Hold clear low with the strobe low, then check the idle levels.
   task automatic do_clear(input logic sr_exp);
      clear_n <= 1'h0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk8(data_outputs, BIOH_REG_CLEAR);
      chk1(service_request, sr_exp);
      @(posedge sys_clk);
      clear_n <= 1'h1;
      repeat (4) @(posedge sys_clk);
   endtask
   // Watchdog against a hang.
   initial begin
      repeat (5000) @(posedge sys_clk);
      fails++;
      close_out();
   end
   // Main sequence.
   initial begin
      void'($urandom(86377));
      repeat (5) @(posedge sys_clk);
      rstn <= 1'h1;
      repeat (3) @(posedge sys_clk);
      // Input mode: five strobes with the drain stalled, so the fifth is dropped.
      for (int i = 0; i < 5; i++) begin
         d = 8'($urandom);
         if (i < 4) q.push_back(d);
         bioh_peri_inst.strobe(d, i % 2);
         @(negedge sys_clk);
         chk1(service_request, 1'h0);
         @(posedge sys_clk);
         bioh_peri_inst.sel(1'h1, 1'h1, 4);
         @(negedge sys_clk);
         chk1(data_outputs_oe, sel_exp(1'h0, 1'h1, 1'h1));
         chk8(data_outputs, d);
         @(posedge sys_clk);
         bioh_peri_inst.sel(i[0], !i[0], 4);
         @(negedge sys_clk);
         chk1(data_outputs_oe, sel_exp(1'h0, i[0], !i[0]));
         chk1(service_request, 1'h1);
         @(posedge sys_clk);
      end
      @(negedge sys_clk);
      chk1(capture_space, 1'h0);
      // Drain the held bytes, stalling a cycle between words.
      while (q.size() > 0) begin
         @(negedge sys_clk);
         chk1(capture_valid, 1'h1);
         chk8(capture_data, q.pop_front());
         @(posedge sys_clk);
         capture_ready <= 1'h1;
         @(posedge sys_clk);
         capture_ready <= 1'h0;
      end
      @(negedge sys_clk);
      chk1(capture_valid, 1'h0);
      @(posedge sys_clk);
      capture_ready <= 1'h1;
      // A short selection alone pulls the request low.
      bioh_peri_inst.sel(1'h1, 1'h1, 3);
      @(negedge sys_clk);
      chk1(service_request, 1'h0);
      @(posedge sys_clk);
      bioh_peri_inst.sel(1'h0, 1'h0, 4);
      bioh_peri_inst.strobe(8'($urandom), 0);
      do_clear(1'h1);
      // Clear held low through a strobe: data passes, then clears, and no request is raised.
      clear_n <= 1'h0;
      d = 8'($urandom);
      bioh_peri_inst.strobe(d, 1);
      @(negedge sys_clk);
      chk8(data_outputs, BIOH_REG_CLEAR);
      chk1(service_request, 1'h1);
      chk1(capture_valid, 1'h0);
      @(posedge sys_clk);
      clear_n <= 1'h1;
      repeat (4) @(posedge sys_clk);
      // Output mode writes, deselected both ways, then a strobe while deselected.
      mode_strap <= 1'h1;
      repeat (8) @(posedge sys_clk);
      for (int i = 0; i < 3; i++) begin
         d = 8'($urandom);
         bioh_peri_inst.sel(1'h0, 1'h1, 3);
         bioh_peri_inst.strobe(d, i);
         bioh_peri_inst.sel(!i[0], !i[0], 4);
         @(negedge sys_clk);
         chk1(data_outputs_oe, 1'h1);
         chk1(service_request, 1'h1);
         chk8(data_outputs, d);
         @(posedge sys_clk);
         bioh_peri_inst.strobe(~d, 0);
         @(negedge sys_clk);
         chk1(service_request, 1'h0);
         chk8(data_outputs, d);
         @(posedge sys_clk);
      end
      do_clear(1'h0);
      close_out();
   end
endmodule
`default_nettype wire
